// *** verilog/alert_pkg.sv ***
// shared constants and types for the fault alert pin logic
package alert_pkg;
    // power mode encoding
    typedef enum logic [1:0]
    {
        MODE_NORMAL    = 2'b00,
        MODE_SLEEP     = 2'b01,
        MODE_HIBERNATE = 2'b10
    } power_mode_t;

    // fault flag vector positions
    localparam int FLAG_COUNT     = 8;
    localparam int FLAG_CHG_THR   = 0;
    localparam int FLAG_BAT_HIGH  = 1;
    localparam int FLAG_BAT_LOW   = 2;
    localparam int FLAG_OT_CHG    = 3;
    localparam int FLAG_OT_DSG    = 4;
    localparam int FLAG_INT_SHORT = 5;
    localparam int FLAG_TAB_DISC  = 6;
    localparam int FLAG_PEAK_CUR  = 7;

    // widths
    localparam int CAP_WIDTH  = 16;
    localparam int TIME_WIDTH = 8;

    // reset values
    localparam logic RST_LOW  = 1'b0;
    localparam logic RST_HIGH = 1'b1;
endpackage

// *** verilog/pin_drive_map.sv ***
// pin level and enable mapping from pullup, polarity and asserted state
`timescale 1ns/10ps
module pin_drive_map
(
    // settings
    input  wire logic pullup_in,
    input  wire logic polarity_in,
    // state: 1 = interrupt set or power-off state
    input  wire logic active_in,
    // drive
    output logic      level_out,
    output logic      oe_out
);
    // pullup off: open drain, low on one state; pullup on: push-pull
    always_comb
    begin
        if (pullup_in)
        begin
            oe_out    = 1'b1;
            level_out = polarity_in ? active_in : ~active_in;
        end
        else
        begin
            level_out = 1'b0;
            oe_out    = polarity_in ? ~active_in : active_in;
        end
    end
endmodule // pin_drive_map

// *** verilog/power_mode_fsm.sv ***
// coarse power mode tracker: normal, sleep, hibernate
`timescale 1ns/10ps
module power_mode_fsm
(
    // clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 arst_n_in,
    // requests
    input  wire logic                 sleep_req_in,
    input  wire logic                 hibernate_req_in,
    input  wire logic                 low_voltage_in,
    input  wire logic                 wake_in,
    // state
    output alert_pkg::power_mode_t    mode_out,
    output logic                      hib_low_v_out
);
    alert_pkg::power_mode_t mode_q;
    logic                   hib_low_v_q;

    // normal leaves only by entering another mode; hibernate wins over sleep
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            mode_q <= alert_pkg::MODE_NORMAL;
        else
        begin
            case (mode_q)
                alert_pkg::MODE_NORMAL:
                    if (hibernate_req_in || low_voltage_in)
                        mode_q <= alert_pkg::MODE_HIBERNATE;
                    else if (sleep_req_in)
                        mode_q <= alert_pkg::MODE_SLEEP;
                alert_pkg::MODE_SLEEP:
                    if (hibernate_req_in || low_voltage_in)
                        mode_q <= alert_pkg::MODE_HIBERNATE;
                    else if (!sleep_req_in || wake_in)
                        mode_q <= alert_pkg::MODE_NORMAL;
                alert_pkg::MODE_HIBERNATE:
                    if (wake_in)
                        mode_q <= alert_pkg::MODE_NORMAL;
                default:
                    mode_q <= alert_pkg::MODE_NORMAL;
            endcase
        end
    end

    // remember why hibernate was entered
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            hib_low_v_q <= alert_pkg::RST_LOW;
        else if (mode_q != alert_pkg::MODE_HIBERNATE)
            hib_low_v_q <= low_voltage_in;
    end

    assign mode_out      = mode_q;
    assign hib_low_v_out = hib_low_v_q;
endmodule // power_mode_fsm

// *** verilog/fault_alert_pin_logic.sv ***
// fault alert / power-off pin controller of a battery gauge
`timescale 1ns/10ps
module fault_alert_pin_logic
(
    // clock and reset
    input  wire logic                            core_clk_in,
    input  wire logic                            arst_n_in,
    // configuration
    input  wire logic                            alert_pin_select_in,
    input  wire logic                            poweroff_enable_cfg_in,
    input  wire logic                            output_pullup_cfg_in,
    input  wire logic                            poweroff_polarity_cfg_in,
    input  wire logic                            alert_polarity_cfg_in,
    input  wire logic [alert_pkg::TIME_WIDTH-1:0] ot_chg_time_in,
    input  wire logic [alert_pkg::TIME_WIDTH-1:0] ot_dsg_time_in,
    input  wire logic                            internal_short_alert_enable_in,
    input  wire logic                            tab_disconnect_alert_enable_in,
    input  wire logic                            peak_current_alert_enable_in,
    input  wire logic                            trip_point_enable_in,
    // host commands
    input  wire logic                            set_poweroff_cmd_in,
    input  wire logic                            clear_poweroff_cmd_in,
    input  wire logic                            trip_set_wr_in,
    input  wire logic                            trip_clear_wr_in,
    input  wire logic [alert_pkg::CAP_WIDTH-1:0]  trip_wdata_in,
    // gauge status
    input  wire logic [alert_pkg::FLAG_COUNT-1:0] fault_flags_in,
    input  wire logic [alert_pkg::CAP_WIDTH-1:0]  remaining_capacity_a_in,
    input  wire logic                            discharging_in,
    input  wire logic                            charging_in,
    // power mode requests
    input  wire logic                            sleep_req_in,
    input  wire logic                            hibernate_req_in,
    input  wire logic                            low_voltage_in,
    input  wire logic                            wake_in,
    // output pin
    output logic                                 poweroff_output_pin_out,
    output logic                                 poweroff_output_pin_oe_out,
    // comm pin interrupt drive (low only)
    output logic                                 single_wire_comm_pin_out,
    output logic                                 single_wire_comm_pin_oe_out,
    // status
    output logic                                 poweroff_armed_bit_out,
    output logic                                 trip_point_alert_out,
    output logic                                 alert_active_out,
    output alert_pkg::power_mode_t               power_mode_out,
    output logic                                 measure_enable_out
);
    ////////////////////////////////////////////////////////////////////////
    // state
    logic                           armed_q;
    logic                           pullup_q;
    logic                           started_q;
    logic [alert_pkg::CAP_WIDTH-1:0] set_thr_q;
    logic [alert_pkg::CAP_WIDTH-1:0] clr_thr_q;
    logic                           set_new_q;
    logic                           clr_new_q;
    logic                           trip_q;
    logic                           alert_q;
    logic                           po_lvl_q;
    logic                           po_oe_q;
    logic                           hq_lvl_q;
    logic                           hq_oe_q;
    logic                           meas_q;
    logic [alert_pkg::FLAG_COUNT-1:0] flag_en;
    logic                           flag_alert;
    logic                           trip_hit;
    logic                           alert_d;
    logic                           poweroff_mode;
    logic                           poweroff_state;
    logic                           map_active;
    logic                           map_pol;
    logic                           map_lvl;
    logic                           map_oe;
    logic                           hib_low_v;
    alert_pkg::power_mode_t         mode;

    ////////////////////////////////////////////////////////////////////////
    // power mode tracker
    power_mode_fsm u_mode
    (
        .core_clk_in      (core_clk_in),
        .arst_n_in        (arst_n_in),
        .sleep_req_in     (sleep_req_in),
        .hibernate_req_in (hibernate_req_in),
        .low_voltage_in   (low_voltage_in),
        .wake_in          (wake_in),
        .mode_out         (mode),
        .hib_low_v_out    (hib_low_v)
    );

    ////////////////////////////////////////////////////////////////////////
    // armed bit: command or enable bit sets, clear command drops it only while neither set source is high
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            armed_q <= alert_pkg::RST_LOW;
        else if (set_poweroff_cmd_in || poweroff_enable_cfg_in)
            armed_q <= 1'b1;
        else if (clear_poweroff_cmd_in)
            armed_q <= 1'b0;
    end

    // pullup is captured once after reset release, so later changes wait for the next reset
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            started_q <= alert_pkg::RST_LOW;
            pullup_q  <= alert_pkg::RST_LOW;
        end
        else if (!started_q)
        begin
            started_q <= 1'b1;
            pullup_q  <= output_pullup_cfg_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-source gating
    always_comb
    begin
        flag_en                           = '0;
        flag_en[alert_pkg::FLAG_CHG_THR]   = 1'b1;
        flag_en[alert_pkg::FLAG_BAT_HIGH]  = 1'b1;
        flag_en[alert_pkg::FLAG_BAT_LOW]   = 1'b1;
        flag_en[alert_pkg::FLAG_OT_CHG]    = |ot_chg_time_in;
        flag_en[alert_pkg::FLAG_OT_DSG]    = |ot_dsg_time_in;
        flag_en[alert_pkg::FLAG_INT_SHORT] = internal_short_alert_enable_in;
        flag_en[alert_pkg::FLAG_TAB_DISC]  = tab_disconnect_alert_enable_in;
        flag_en[alert_pkg::FLAG_PEAK_CUR]  = peak_current_alert_enable_in;
    end

    assign flag_alert = |(fault_flags_in & flag_en);

    ////////////////////////////////////////////////////////////////////////
    // trip thresholds and new-value tracking
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            set_thr_q <= '0;
            clr_thr_q <= '1;
        end
        else
        begin
            if (trip_set_wr_in)
                set_thr_q <= trip_wdata_in;
            if (trip_clear_wr_in)
                clr_thr_q <= trip_wdata_in;
        end
    end

    // a write fresh after latching counts toward release; both needed
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            set_new_q <= alert_pkg::RST_LOW;
            clr_new_q <= alert_pkg::RST_LOW;
        end
        else if (trip_q && (set_new_q || trip_set_wr_in) && (clr_new_q || trip_clear_wr_in))
        begin
            set_new_q <= 1'b0;
            clr_new_q <= 1'b0;
        end
        else if (trip_q)
        begin
            set_new_q <= set_new_q || trip_set_wr_in;
            clr_new_q <= clr_new_q || trip_clear_wr_in;
        end
        else
        begin
            set_new_q <= 1'b0;
            clr_new_q <= 1'b0;
        end
    end

    assign trip_hit = (discharging_in && (remaining_capacity_a_in <= set_thr_q))
                   || (charging_in && (remaining_capacity_a_in >= clr_thr_q));

    // trip latch: a hit sets it only while clear; once set, both writes release it even while the hit persists
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            trip_q <= alert_pkg::RST_LOW;
        else if (!trip_point_enable_in)
            trip_q <= 1'b0;
        else if (trip_hit && !trip_q)
            trip_q <= 1'b1;
        else if (trip_q && (set_new_q || trip_set_wr_in) && (clr_new_q || trip_clear_wr_in))
            trip_q <= 1'b0;
    end

    // trip mode hides every other source
    assign alert_d = trip_point_enable_in ? trip_q : flag_alert;

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            alert_q <= alert_pkg::RST_LOW;
        else
            alert_q <= alert_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // pin function and drive
    assign poweroff_mode  = alert_pin_select_in && (poweroff_enable_cfg_in || armed_q);
    assign poweroff_state = (mode == alert_pkg::MODE_HIBERNATE) && hib_low_v;
    assign map_active     = poweroff_mode ? poweroff_state : alert_q;
    assign map_pol        = poweroff_mode ? poweroff_polarity_cfg_in : alert_polarity_cfg_in;

    pin_drive_map u_pin_map
    (
        .pullup_in   (pullup_q),
        .polarity_in (map_pol),
        .active_in   (map_active),
        .level_out   (map_lvl),
        .oe_out      (map_oe)
    );

    // output pin: interrupt when select 0, power-off when armed, else released
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            po_lvl_q <= alert_pkg::RST_LOW;
            po_oe_q  <= alert_pkg::RST_LOW;
        end
        else if (!started_q)
        begin
            po_lvl_q <= 1'b0;
            po_oe_q  <= 1'b0;
        end
        else if (!alert_pin_select_in || poweroff_mode)
        begin
            po_lvl_q <= map_lvl;
            po_oe_q  <= map_oe;
        end
        else
        begin
            po_lvl_q <= 1'b0;
            po_oe_q  <= 1'b0;
        end
    end

    // comm pin: open drain low only, no pullup option
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            hq_lvl_q <= alert_pkg::RST_LOW;
            hq_oe_q  <= alert_pkg::RST_LOW;
        end
        else
        begin
            hq_lvl_q <= 1'b0;
            hq_oe_q  <= alert_pin_select_in && (alert_polarity_cfg_in ? ~alert_q : alert_q);
        end
    end

    // measurements run in normal and sleep, halted in hibernate
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            meas_q <= alert_pkg::RST_LOW;
        else
            meas_q <= (mode != alert_pkg::MODE_HIBERNATE);
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign poweroff_output_pin_out     = po_lvl_q;
    assign poweroff_output_pin_oe_out  = po_oe_q;
    assign single_wire_comm_pin_out    = hq_lvl_q;
    assign single_wire_comm_pin_oe_out = hq_oe_q;
    assign poweroff_armed_bit_out      = armed_q;
    assign trip_point_alert_out        = trip_q;
    assign alert_active_out            = alert_q;
    assign power_mode_out              = mode;
    assign measure_enable_out          = meas_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_trip_hides_flags: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        trip_point_enable_in |=> (alert_q == $past(trip_q)))
        else $error("trip mode did not supersede flags");
    a_trip_holds_latch: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (trip_q && trip_point_enable_in && !trip_set_wr_in && !trip_clear_wr_in && !set_new_q) |=> trip_q)
        else $error("trip alert released without both writes");
    a_trip_fires: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (trip_point_enable_in && !trip_q && trip_hit) |=> trip_q)
        else $error("trip hit not latched");
    a_flag_or_follows: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        !trip_point_enable_in |=> (alert_q == $past(flag_alert)))
        else $error("alert not OR of enabled flags");
    a_overtemp_gated: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (!trip_point_enable_in && ot_chg_time_in == '0 && fault_flags_in == (1 << alert_pkg::FLAG_OT_CHG))
        |=> !alert_q)
        else $error("overtemp charge alerted with zero time");
    a_armed_sets: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        set_poweroff_cmd_in |=> armed_q)
        else $error("armed bit not set by command");
    a_comm_idle_sel0: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        !alert_pin_select_in |=> !hq_oe_q)
        else $error("comm pin driven while select is 0");
    a_reset_hiz_pin: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        !started_q |=> !po_oe_q)
        else $error("output pin driven right after reset");
    a_pullup_static: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        started_q |=> $stable(pullup_q))
        else $error("pullup changed without reset");
    a_poweroff_normal: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (started_q && poweroff_mode && mode != alert_pkg::MODE_HIBERNATE && pullup_q)
        |=> (po_lvl_q == ~$past(poweroff_polarity_cfg_in)))
        else $error("power-off pin left normal state outside hibernate");
endmodule // fault_alert_pin_logic

// *** testbench/host_pin_monitor.sv ***
// partner model: host view of the alert and power-off pins
`timescale 1ns/10ps
module host_pin_monitor
(
    // drive from the gauge
    input  wire logic       level_in,
    input  wire logic       oe_in,
    // wire seen by host: 0 low, 1 high, 2 released
    output logic [1:0]      state_out
);
    ////////////////////////////////////////
    // released gets its own code so high-Z never passes for a level
    assign state_out = oe_in ? {1'b0, level_in} : 2'h2;
endmodule // host_pin_monitor

// *** testbench/fault_alert_pin_logic_tb.sv ***
// testbench for the fault alert pin logic
`timescale 1ns/10ps
module fault_alert_pin_logic_tb;
    logic clk, rst_n, sel, po_en, pu, po_pol, i_pol, sh_en, td_en, pk, tp, scmd, ccmd, swr, cwr, dsg, chg, slp, hib, lowv, wk;
    logic [7:0]  ot_c, ot_d, flg;
    logic [15:0] wd, cap;
    logic        po_l, po_oe, sw_l, sw_oe, armed, trip, alert, meas;
    logic [1:0]  po_st, sw_st;
    alert_pkg::power_mode_t mode;
    int          n_mismatch, n_checks;
    ////////////////////////////////////////
    // clock, 25 ns period
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    fault_alert_pin_logic dut_u (.core_clk_in(clk), .arst_n_in(rst_n), .alert_pin_select_in(sel),
        .poweroff_enable_cfg_in(po_en), .output_pullup_cfg_in(pu), .poweroff_polarity_cfg_in(po_pol),
        .alert_polarity_cfg_in(i_pol), .ot_chg_time_in(ot_c), .ot_dsg_time_in(ot_d),
        .internal_short_alert_enable_in(sh_en), .tab_disconnect_alert_enable_in(td_en),
        .peak_current_alert_enable_in(pk), .trip_point_enable_in(tp), .set_poweroff_cmd_in(scmd),
        .clear_poweroff_cmd_in(ccmd), .trip_set_wr_in(swr), .trip_clear_wr_in(cwr), .trip_wdata_in(wd),
        .fault_flags_in(flg), .remaining_capacity_a_in(cap), .discharging_in(dsg), .charging_in(chg),
        .sleep_req_in(slp), .hibernate_req_in(hib), .low_voltage_in(lowv), .wake_in(wk),
        .poweroff_output_pin_out(po_l), .poweroff_output_pin_oe_out(po_oe), .single_wire_comm_pin_out(sw_l),
        .single_wire_comm_pin_oe_out(sw_oe), .poweroff_armed_bit_out(armed), .trip_point_alert_out(trip),
        .alert_active_out(alert), .power_mode_out(mode), .measure_enable_out(meas));
    host_pin_monitor po_u (.level_in(po_l), .oe_in(po_oe), .state_out(po_st));
    host_pin_monitor sw_u (.level_in(sw_l), .oe_in(sw_oe), .state_out(sw_st));
    ////////////////////////////////////////
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [15:0] e, input logic [15:0] a);
        n_checks++;
        if (a !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t exp=%h act=%h", $time, e, a);
        end
    endtask
    // pin table: push-pull with pullup, else low-only open drain
    function automatic logic [1:0] pin(input logic u, input logic p, input logic a);
        return u ? {1'b0, a ~^ p} : ((a != p) ? 2'h0 : 2'h2);
    endfunction
    // every input idle, pullup chosen, reset held five cycles
    task automatic rst(input logic u);
        {sel, po_en, po_pol, i_pol, sh_en, td_en, pk, tp, scmd, ccmd, swr, cwr, dsg, chg, slp, hib, lowv, wk} = '0;
        {ot_c, ot_d, flg, wd, cap} = '0;
        pu = u;
        rst_n = 1'b0;
        cyc(5);
        rst_n = 1'b1;
    endtask
    task automatic wr(input logic s, input logic c, input logic [15:0] v);
        swr = s;
        cwr = c;
        wd = v;
        cyc(1);
        {swr, cwr} = 2'b00;
    endtask
    ////////////////////////////////////////
    // scenarios
    task automatic t_int;
        for (int u = 0; u < 2; u++)
        begin
            rst(u[0]);
            chk(2'h2, po_st);
            cyc(1);
            chk(2'h2, po_st);
            for (int p = 0; p < 4; p++)
            begin
                {i_pol, flg[2]} = p[1:0];
                cyc(3);
                chk(pin(u[0], p[1], p[0]), po_st);
                chk(p[0], alert);
            end
            pu = ~pu;
            cyc(3);
            chk(pin(u[0], 1'b1, 1'b1), po_st);
        end
        $display("test int_pin done");
    endtask
    task automatic t_gate;
        rst(1'b0);
        for (int i = 0; i < 16; i++)
        begin
            flg = 8'h01 << i[3:1];
            {sh_en, td_en, pk} = {3{i[0]}};
            ot_c = {7'h00, i[0]};
            ot_d = {7'h00, i[0]};
            cyc(2);
            chk(i[0] | (i < 6), alert);
            flg = 8'h00;
            cyc(2);
            chk(1'b0, alert);
        end
        $display("test gating done");
    endtask
    task automatic t_comm;
        rst(1'b0);
        sel = 1'b1;
        for (int p = 0; p < 4; p++)
        begin
            {i_pol, flg[0]} = p[1:0];
            cyc(3);
            chk((p[1] != p[0]) ? 2'h0 : 2'h2, sw_st);
            chk(2'h2, po_st);
        end
        $display("test comm_pin done");
    endtask
    task automatic t_trip;
        rst(1'b0);
        {tp, sh_en, td_en, pk, flg} = {4'hf, 8'hff};
        wr(1'b1, 1'b0, 16'h0064);
        wr(1'b0, 1'b1, 16'h00c8);
        {dsg, cap} = {1'b1, 16'h0064};
        cyc(3);
        chk(1'b1, trip);
        chk(1'b1, alert);
        cap = 16'h01f4;
        wr(1'b1, 1'b0, 16'h0064);
        cyc(2);
        chk(1'b1, trip);
        wr(1'b0, 1'b1, 16'h00c8);
        cyc(2);
        chk(1'b0, trip);
        chk(1'b0, alert);
        {dsg, chg, cap} = {2'b01, 16'h00c7};
        cyc(2);
        chk(1'b0, trip);
        cap = 16'h00c8;
        cyc(2);
        chk(1'b1, trip);
        tp = 1'b0;
        cyc(3);
        chk({1'b0, 1'b1}, {trip, alert});
        $display("test trip done");
    endtask
    task automatic t_poff;
        for (int p = 0; p < 4; p++)
        begin
            rst(p[1]);
            {sel, po_pol, scmd} = {1'b1, p[0], 1'b1};
            cyc(1);
            scmd = 1'b0;
            cyc(1);
            chk(1'b1, armed);
            chk(pin(p[1], p[0], 1'b0), po_st);
            lowv = 1'b1;
            cyc(3);
            chk({alert_pkg::MODE_HIBERNATE, 1'b0}, {mode, meas});
            chk(pin(p[1], p[0], 1'b1), po_st);
            {lowv, wk} = 2'b01;
            cyc(3);
            wk = 1'b0;
            chk(alert_pkg::MODE_NORMAL, mode);
            chk(pin(p[1], p[0], 1'b0), po_st);
            {ccmd, po_en} = 2'b10;
            cyc(1);
            ccmd = 1'b0;
            cyc(1);
            chk(1'b0, armed);
            {po_en, hib} = 2'b11;
            cyc(3);
            chk({1'b1, alert_pkg::MODE_HIBERNATE}, {armed, mode});
            chk(pin(p[1], p[0], 1'b0), po_st);
        end
        $display("test poweroff done");
    endtask
    task automatic t_sleep;
        rst(1'b0);
        cyc(2);
        chk({alert_pkg::MODE_NORMAL, 1'b1}, {mode, meas});
        slp = 1'b1;
        cyc(2);
        chk({alert_pkg::MODE_SLEEP, 1'b1}, {mode, meas});
        slp = 1'b0;
        cyc(2);
        chk(alert_pkg::MODE_NORMAL, mode);
        $display("test sleep done");
    endtask
    ////////////////////////////////////////
    // closing report, reached from the main sequence or the watchdog
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        n_mismatch = 0;
        n_checks = 0;
        t_int();
        t_gate();
        t_comm();
        t_trip();
        t_poff();
        t_sleep();
        wrap_up();
    end
    // bounded run: a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
endmodule // fault_alert_pin_logic_tb
